/* File: otseq_regs.svh */
// register map, field positions, reset values and timing counts of the transient sequencer
// assumes a 32-bit AHB-Lite slave decoding the low 12 address bits
`ifndef OTSEQ_REGS_SVH
`define OTSEQ_REGS_SVH

`define OFS_CTRL      12'h000
`define OFS_CONFIG    12'h004
`define OFS_STATUS    12'h008
`define OFS_PCOUNT    12'h00c
`define OFS_PPERIOD   12'h010
`define OFS_PWIDTH    12'h014
`define OFS_PDUTY     12'h018
`define OFS_LCOUNT    12'h01c
`define OFS_DLEN      12'h078
`define BLK_IMM       7'h01
`define BLK_TRG       7'h02
`define BLK_LEN       7'h03
`define BLK_OUT       7'h04
`define RGN_LIST      5'h04
`define RGN_LIST_LAST 5'h09
`define RGN_DWELL     5'h0a
`define RGN_REP       5'h0b

`define CTRL_INIT     0
`define CTRL_ABORT    1
`define CTRL_DEVCLR   2
`define CTRL_TRIG     3
`define CFG_MODE      0
`define CFG_ONCE      2
`define CFG_CONT      3
`define CFG_MASK      8
`define ST_STATE      0
`define ST_ERR        3
`define ST_EXEC       4
`define ST_RUN        5
`define ST_PT         8

`define RST_LCOUNT    32'h0000_0001
`define RST_PCOUNT    32'h0000_0001
`define RST_LEN       6'h01
`define RST_REPEAT    16'h0001

`define TICK_NS       1000
`define CLK_PERIOD_NS 25
`define TICK_CYCLES   ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PCT_FULL      40'd100

`endif

/* File: otseq_pkg.sv */
// types shared by the transient sequencer and its bench
// assumes six controlled functions of 16-bit setting each
package otseq_pkg;
  localparam int NFUNC = 6;
  typedef logic [15:0] fval_t;
  typedef fval_t [NFUNC-1:0] fset_t;
  typedef enum logic [1:0] {MODE_FIXED, MODE_STEP, MODE_PULSE, MODE_LIST} tmode_t;
  typedef enum logic [2:0] {S_IDLE, S_INIT, S_PHI, S_PLO, S_DWELL} tstate_t;
  typedef struct packed {
    fval_t freq_slew;
    fval_t volt_slew;
    fval_t phase;
    fval_t freq;
    fval_t dc_volt;
    fval_t ac_volt;
  } out_set_t;
endpackage

/* File: output_transient_sequencer.sv */
// output transient sequencer: fixed, single-change, timed-excursion and list modes
// assumes one AHB-Lite master, a 40 MHz ref_clk and an asynchronous trigger pin
//
// Notes on behaviour
// - reset or device clear puts all functions in fixed mode
// - fixed mode outputs only the immediate value
// - controlled: ac volt, dc volt, frequency, phase, volt slew, freq slew
// - single change: trigger outputs triggered value, which becomes immediate
// - excursion: triggered value while high, immediate value while low
// - after the last excursion, outputs hold the immediate value
// - list end holds the final list value
// - only one transient mode at a time across functions
// - up to 32 list points, each with a dwell time
// - per point repeat count and whole list execution count
// - points are output in the order supplied
// - initiate raises an error on unequal list lengths, ignoring single entries
// - single entry list expands to common length
// - dwell list matches point count or single dwell applies to all
// - dwell counted in time units, hold before advancing
// - list execution count is one after reset
// - time paced advance, the reset default, moves on when dwell expires
// - trigger paced advance moves exactly one point per accepted trigger
// - triggers during an unexpired dwell are discarded
// - list may be saved only after one execution
// - after the action, return to idle unless continuous
// - abort or reset returns to idle from any state
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "otseq_regs.svh"
module output_transient_sequencer #(
  parameter int MAX_POINTS = 32
) (
  input  logic                ref_clk,
  input  logic                reset,
  input  logic                hsel,
  input  logic [31:0]         haddr,
  input  logic [1:0]          htrans,
  input  logic                hwrite,
  input  logic [2:0]          hsize,
  input  logic [31:0]         hwdata,
  input  logic                hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  input  logic                trig_in,
  output otseq_pkg::out_set_t out_set,
  output logic                seq_busy,
  output logic                list_done,
  output logic                save_ok
);
  localparam int          NF        = otseq_pkg::NFUNC;
  localparam logic [5:0]  TICK_LAST = 6'(`TICK_CYCLES - 1);
  localparam logic [5:0]  MAXP      = 6'(MAX_POINTS);

  if (MAX_POINTS < 2 || MAX_POINTS > 32) begin : g_points_bad
    $error("MAX_POINTS must lie in 2..32");
  end
  if (`TICK_CYCLES > 64) begin : g_tick_bad
    $error("time tick does not fit the prescaler");
  end

  typedef struct packed {
    otseq_pkg::tstate_t state;
    otseq_pkg::tmode_t  mode;
    logic               once;
    logic               cont;
    logic [NF-1:0]      mask;
    logic [31:0]        pcount;
    logic [31:0]        pper;
    logic [31:0]        pwid;
    logic [7:0]         pduty;
    logic [31:0]        lcount;
    otseq_pkg::fset_t   imm;
    otseq_pkg::fset_t   trg;
    otseq_pkg::fset_t   outv;
    logic [NF-1:0][5:0] llen;
    logic [5:0]         dlen;
    logic               err_len;
    logic               executed;
    logic               in_list;
    logic               done;
    logic               busy;
    logic [5:0]         tick;
    logic [31:0]        tmr;
    logic [31:0]        pulses;
    logic [31:0]        passes;
    logic [15:0]        reps;
    logic [4:0]         pt;
    logic [5:0]         npts;
    logic [2:0]         sync;
    logic               wr_pend;
    logic               rd_pend;
    logic               hit;
    logic               hready_o;
    logic [11:0]        addr;
    logic [31:0]        hrdata;
  } st_t;

  localparam st_t ST_RST = '{state: otseq_pkg::S_IDLE, mode: otseq_pkg::MODE_FIXED,
                             pcount: `RST_PCOUNT, lcount: `RST_LCOUNT,
                             llen: {NF{`RST_LEN}}, dlen: `RST_LEN, hready_o: 1'b1, default: '0};

  st_t s;
  st_t n;

  otseq_pkg::fval_t list_mem  [NF][MAX_POINTS];
  logic [31:0]      dwell_mem [MAX_POINTS];
  logic [15:0]      rep_mem   [MAX_POINTS];

  logic [31:0] rd_word;
  logic [3:0]  cmd;
  logic        trig;
  logic [5:0]  common;
  logic        len_bad;
  logic [39:0] duty_prod;
  logic [31:0] hi_us;
  logic [31:0] lo_us;
  logic        ap_go;
  logic [4:0]  ap_pt;
  logic [4:0]  nxt;
  logic        last;
  otseq_pkg::tstate_t after;

  wire       low_bank = s.hit && (s.addr[11:9] == 3'h0);
  wire [6:0] blk      = s.addr[11:5];
  wire [2:0] widx     = s.addr[4:2];
  wire [4:0] rgn      = s.addr[11:7];
  wire [4:0] midx     = s.addr[6:2];
  wire       midx_ok  = {1'b0, midx} < MAXP;
  wire       wr_mem   = s.wr_pend && s.hit && !low_bank && midx_ok;

  // repeat count of zero is read as one pass of the point
  function automatic logic [15:0] rep_at(input logic [4:0] i);
    rep_at = (rep_mem[i] == 16'h0) ? `RST_REPEAT : rep_mem[i];
  endfunction

  // length check at initiate; single-entry lists stretch to the common length
  always_comb begin
    common  = 6'h01;
    len_bad = 1'b0;
    for (int f = 0; f < NF; f++) begin
      if (s.mask[f] && s.llen[f] > common) common = s.llen[f];
    end
    if (common > MAXP) len_bad = 1'b1;
    for (int f = 0; f < NF; f++) begin
      if (s.mask[f] && s.llen[f] != common && s.llen[f] != 6'h01) len_bad = 1'b1;
    end
    if (s.dlen != common && s.dlen != 6'h01) len_bad = 1'b1;
  end

  // width wins over duty when both were given, so a late duty write cannot undo a width
  always_comb begin
    duty_prod = s.pper * s.pduty;
    hi_us     = (s.pwid != 32'h0) ? s.pwid : 32'(duty_prod / `PCT_FULL);
    lo_us     = (s.pper > hi_us) ? s.pper - hi_us : 32'h0;
  end

  always_comb begin
    rd_word = 32'h0;
    if (low_bank) begin
      case (blk)
        7'h00: begin
          case (s.addr)
            `OFS_CONFIG: begin
              rd_word[`CFG_MODE +: 2]  = s.mode;
              rd_word[`CFG_ONCE]       = s.once;
              rd_word[`CFG_CONT]       = s.cont;
              rd_word[`CFG_MASK +: NF] = s.mask;
            end
            `OFS_STATUS: begin
              rd_word[`ST_STATE +: 3] = s.state;
              rd_word[`ST_ERR]        = s.err_len;
              rd_word[`ST_EXEC]       = s.executed;
              rd_word[`ST_RUN]        = s.in_list;
              rd_word[`ST_PT +: 5]    = s.pt;
            end
            `OFS_PCOUNT:  rd_word = s.pcount;
            `OFS_PPERIOD: rd_word = s.pper;
            `OFS_PWIDTH:  rd_word = s.pwid;
            `OFS_PDUTY:   rd_word = {24'h0, s.pduty};
            `OFS_LCOUNT:  rd_word = s.lcount;
            default:      rd_word = 32'h0;
          endcase
        end
        `BLK_IMM: if (widx < 3'(NF)) rd_word = {16'h0, s.imm[widx]};
        `BLK_TRG: if (widx < 3'(NF)) rd_word = {16'h0, s.trg[widx]};
        `BLK_LEN: begin
          if (widx < 3'(NF)) rd_word = {26'h0, s.llen[widx]};
          else if (s.addr == `OFS_DLEN) rd_word = {26'h0, s.dlen};
        end
        `BLK_OUT: if (widx < 3'(NF)) rd_word = {16'h0, s.outv[widx]};
        default: rd_word = 32'h0;
      endcase
    end else if (s.hit && midx_ok) begin
      if (rgn >= `RGN_LIST && rgn <= `RGN_LIST_LAST) rd_word = {16'h0, list_mem[3'(rgn - `RGN_LIST)][midx]};
      else if (rgn == `RGN_DWELL) rd_word = dwell_mem[midx];
      else if (rgn == `RGN_REP) rd_word = {16'h0, rep_mem[midx]};
    end
  end

  always_comb begin
    n      = s;
    cmd    = 4'h0;
    ap_go  = 1'b0;
    ap_pt  = s.pt;
    nxt    = s.pt;
    last   = 1'b0;
    after  = s.cont ? otseq_pkg::S_INIT : otseq_pkg::S_IDLE;
    n.done = 1'b0;
    n.sync = {s.sync[1:0], trig_in};
    // bus: writes commit in the data phase, reads take one wait state so a read
    // right after a write sees the written value
    n.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.addr    = haddr[11:0];
      n.hit     = (haddr[31:12] == 20'h0);
      n.wr_pend = hwrite;
      if (!hwrite) begin
        n.rd_pend  = 1'b1;
        n.hready_o = 1'b0;
      end
    end
    if (s.rd_pend) begin
      n.rd_pend  = 1'b0;
      n.hready_o = 1'b1;
      n.hrdata   = rd_word;
    end
    if (s.wr_pend && low_bank) begin
      case (blk)
        7'h00: begin
          case (s.addr)
            `OFS_CTRL: cmd = hwdata[3:0];
            `OFS_CONFIG: begin
              n.mode = otseq_pkg::tmode_t'(hwdata[`CFG_MODE +: 2]);
              n.once = hwdata[`CFG_ONCE];
              n.cont = hwdata[`CFG_CONT];
              n.mask = hwdata[`CFG_MASK +: NF];
            end
            `OFS_PCOUNT:  n.pcount = hwdata;
            `OFS_PPERIOD: n.pper   = hwdata;
            `OFS_PWIDTH:  n.pwid   = hwdata;
            `OFS_PDUTY:   n.pduty  = hwdata[7:0];
            `OFS_LCOUNT:  n.lcount = hwdata;
            default:      n.pcount = s.pcount;
          endcase
        end
        `BLK_IMM: if (widx < 3'(NF)) n.imm[widx] = hwdata[15:0];
        `BLK_TRG: if (widx < 3'(NF)) n.trg[widx] = hwdata[15:0];
        `BLK_LEN: begin
          n.executed = 1'b0;
          if (widx < 3'(NF)) n.llen[widx] = hwdata[5:0];
          else if (s.addr == `OFS_DLEN) n.dlen = hwdata[5:0];
        end
        default: n.mask = s.mask;
      endcase
    end
    if (wr_mem && rgn >= `RGN_LIST && rgn <= `RGN_REP) n.executed = 1'b0;

    // microsecond prescaler, restarted on every load so a time of d counts d*40 clocks
    if (s.tmr != 32'h0) begin
      if (s.tick == TICK_LAST) begin
        n.tick = 6'h00;
        n.tmr  = s.tmr - 32'h1;
      end else begin
        n.tick = 6'(s.tick + 6'h01);
      end
    end

    trig = (s.sync[1] && !s.sync[2]) || cmd[`CTRL_TRIG];
    if (cmd[`CTRL_DEVCLR]) begin
      n.mode    = otseq_pkg::MODE_FIXED;
      n.state   = otseq_pkg::S_IDLE;
      n.in_list = 1'b0;
    end else if (cmd[`CTRL_ABORT]) begin
      n.state   = otseq_pkg::S_IDLE;
      n.in_list = 1'b0;
    end else begin
      case (s.state)
        otseq_pkg::S_IDLE: begin
          // triggers are ignored until initiated
          if (cmd[`CTRL_INIT]) begin
            n.err_len = (s.mode == otseq_pkg::MODE_LIST) && len_bad;
            if (!n.err_len) begin
              n.state   = otseq_pkg::S_INIT;
              n.npts    = common;
              n.in_list = 1'b0;
            end
          end
        end
        otseq_pkg::S_INIT: begin
          if (trig) begin
            case (s.mode)
              otseq_pkg::MODE_STEP: begin
                for (int f = 0; f < NF; f++) begin
                  if (s.mask[f]) n.imm[f] = s.trg[f];
                end
                n.done  = 1'b1;
                n.state = after;
              end
              otseq_pkg::MODE_PULSE: begin
                n.pulses = (s.pcount == 32'h0) ? 32'h1 : s.pcount;
                n.tmr    = hi_us;
                n.tick   = 6'h00;
                n.state  = otseq_pkg::S_PHI;
              end
              otseq_pkg::MODE_LIST: begin
                ap_go = 1'b1;
                if (!s.in_list) begin
                  ap_pt     = 5'h00;
                  n.in_list = 1'b1;
                  n.passes  = (s.lcount == 32'h0) ? 32'h1 : s.lcount;
                  n.reps    = rep_at(5'h00);
                end
              end
              default: n.state = after;
            endcase
          end
        end
        otseq_pkg::S_PHI: begin
          if (s.tmr == 32'h0) begin
            n.tmr   = lo_us;
            n.tick  = 6'h00;
            n.state = otseq_pkg::S_PLO;
          end
        end
        otseq_pkg::S_PLO: begin
          if (s.tmr == 32'h0) begin
            if (s.pulses <= 32'h1) begin
              n.done  = 1'b1;
              n.state = after;
            end else begin
              n.pulses = s.pulses - 32'h1;
              n.tmr    = hi_us;
              n.tick   = 6'h00;
              n.state  = otseq_pkg::S_PHI;
            end
          end
        end
        otseq_pkg::S_DWELL: begin
          // triggers are simply not looked at here
          if (s.tmr == 32'h0) begin
            if (s.reps > 16'h1) begin
              // a repeated point holds for its full dwell again
              n.reps = s.reps - 16'h1;
              n.tmr  = dwell_mem[(s.dlen == 6'h01) ? 5'h00 : s.pt];
              n.tick = 6'h00;
            end else begin
              if ({1'b0, s.pt} + 6'h01 >= s.npts) begin
                if (s.passes > 32'h1) begin
                  n.passes = s.passes - 32'h1;
                  nxt      = 5'h00;
                end else begin
                  last = 1'b1;
                end
              end else begin
                nxt = 5'(s.pt + 5'h01);
              end
              n.reps = rep_at(nxt);
            end
            if (last) begin
              n.in_list  = 1'b0;
              n.executed = 1'b1;
              n.done     = 1'b1;
              n.state    = after;
            end else if (s.once) begin
              n.pt    = nxt;
              n.state = otseq_pkg::S_INIT;
            end else begin
              ap_go = 1'b1;
              ap_pt = nxt;
            end
          end
        end
        default: n.state = otseq_pkg::S_IDLE;
      endcase
    end

    if (ap_go) begin
      n.pt = ap_pt;
      for (int f = 0; f < NF; f++) begin
        if (s.mask[f]) n.outv[f] = list_mem[f][(s.llen[f] == 6'h01) ? 5'h00 : ap_pt];
      end
      n.tmr   = dwell_mem[(s.dlen == 6'h01) ? 5'h00 : ap_pt];
      n.tick  = 6'h00;
      n.state = otseq_pkg::S_DWELL;
    end

    // list outputs keep their last point; excursion outputs show the triggered value in S_PHI, every other output the immediate value
    for (int f = 0; f < NF; f++) begin
      if (!(n.mode == otseq_pkg::MODE_LIST && n.mask[f])) begin
        n.outv[f] = (n.mode == otseq_pkg::MODE_PULSE && n.mask[f] && n.state == otseq_pkg::S_PHI) ?
                    n.trg[f] : n.imm[f];
      end
    end
    n.busy = (n.state != otseq_pkg::S_IDLE);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // list storage has no reset; contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (wr_mem) begin
      if (rgn >= `RGN_LIST && rgn <= `RGN_LIST_LAST) list_mem[3'(rgn - `RGN_LIST)][midx] <= hwdata[15:0];
      else if (rgn == `RGN_DWELL) dwell_mem[midx] <= hwdata;
      else if (rgn == `RGN_REP) rep_mem[midx] <= hwdata[15:0];
    end
  end

  assign hreadyout = s.hready_o;
  assign hresp     = 1'b0;
  assign hrdata    = s.hrdata;
  assign out_set   = otseq_pkg::out_set_t'(s.outv);
  assign seq_busy  = s.busy;
  assign list_done = s.done;
  assign save_ok   = s.executed;

  fixed_output_a: assert property (@(posedge ref_clk) disable iff (reset)
    s.mode == otseq_pkg::MODE_FIXED |-> s.outv == s.imm)
    else $error("fixed mode output differs from immediate value");

  dev_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    cmd[`CTRL_DEVCLR] |=> s.mode == otseq_pkg::MODE_FIXED && s.state == otseq_pkg::S_IDLE)
    else $error("device clear did not restore fixed mode");

  abort_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
    cmd[`CTRL_ABORT] |=> s.state == otseq_pkg::S_IDLE && !s.in_list)
    else $error("abort did not return to idle");

  step_change_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s.state == otseq_pkg::S_INIT && s.mode == otseq_pkg::MODE_STEP && trig && s.mask[0]
     && !cmd[`CTRL_DEVCLR] && !cmd[`CTRL_ABORT])
    |=> s.imm[0] == $past(s.trg[0]) && s.outv[0] == $past(s.trg[0]))
    else $error("single change did not adopt triggered value");

  excursion_level_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s.mode == otseq_pkg::MODE_PULSE && s.mask[1])
    |-> s.outv[1] == ((s.state == otseq_pkg::S_PHI) ? s.trg[1] : s.imm[1]))
    else $error("excursion level wrong");

  list_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    ($past(s.state) == otseq_pkg::S_DWELL && s.state != otseq_pkg::S_DWELL && s.mode == otseq_pkg::MODE_LIST
     && $stable(s.mode) && s.mask[0] && $stable(s.mask)) |-> s.outv[0] == $past(s.outv[0]))
    else $error("list output not held at end");

  dwell_guard_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s.state == otseq_pkg::S_DWELL && s.tmr != 32'h0 && !cmd[`CTRL_DEVCLR] && !cmd[`CTRL_ABORT])
    |=> s.state == otseq_pkg::S_DWELL && $stable(s.pt))
    else $error("list moved before dwell expired");

  length_error_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s.state == otseq_pkg::S_IDLE && cmd == 4'h1 && s.mode == otseq_pkg::MODE_LIST && len_bad)
    |=> s.err_len && s.state == otseq_pkg::S_IDLE)
    else $error("list length mismatch not flagged");

  tick_count_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s.tmr == 32'h1 && s.tick == 6'h00 && s.state == otseq_pkg::S_DWELL && cmd == 4'h0)
    |-> ##39 (s.tmr == 32'h1) ##1 (s.tmr == 32'h0))
    else $error("dwell unit is not 40 clocks");

  list_count_rst_a: assert property (@(posedge ref_clk)
    $past(reset) && !reset |-> s.lcount == `RST_LCOUNT && !s.once)
    else $error("list defaults wrong after reset");
endmodule

/* File: ctrl_model.sv */
// remote controller model: single-word ahb-lite master and trigger pin driver
// assumes the one slave's hreadyout is looped back as hready
`timescale 1ns/1ps
module ctrl_model (
  input  logic        ref_clk,
  input  logic        hreadyout,
  input  logic [31:0] hrdata,
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata,
  output logic        trig_in
);
  int to_n = 0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    trig_in = 1'b0;
  end
  // no wait count is assumed; a stuck slave is cut off and counted
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 64) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 64) to_n++;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  // pin held over the synchroniser depth so the edge is never missed
  task automatic pin_trig();
    trig_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    trig_in <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule

/* File: tb.sv */
// self-checking bench for the output transient sequencer
// assumes ctrl_model as bus master and trigger source, 40 MHz ref_clk
`timescale 1ns/1ps
`include "otseq_regs.svh"
module tb;
  typedef struct packed {
    logic [11:0] wa;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [31:0] ex;
  } row_t;
  logic                ref_clk = 1'b0;
  logic                reset = 1'b1;
  logic                hsel, hwrite, hreadyout, hresp, trig_in, seq_busy, list_done, save_ok;
  logic [31:0]         haddr, hwdata, hrdata, d;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [15:0]         last;
  logic [15:0]         q[$];
  otseq_pkg::out_set_t out_set;
  int                  fails = 0;
  int                  tests_run = 0;
  int                  dn = 0;
  int                  hi, rise, prev, cur;
  row_t rows[9] = '{'{12'h020, 32'h1234, 12'h080, 32'h1234}, '{12'h024, 32'h66, 12'h084, 32'h66},
    '{12'h028, 32'h3c, 12'h088, 32'h3c}, '{12'h02c, 32'h5a, 12'h08c, 32'h5a},
    '{12'h030, 32'h0a, 12'h090, 32'h0a}, '{12'h034, 32'h05, 12'h094, 32'h05},
    '{12'h040, 32'haa, 12'h080, 32'h1234}, '{`OFS_PDUTY, 32'h132, `OFS_PDUTY, 32'h32},
    '{12'hffc, 32'h07, 12'hffc, 32'h0}};
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (list_done === 1'b1) dn++;
  // a bus wait that ran out ends the run at once
  always @(posedge ref_clk) begin
    if (u_ctrl.to_n != 0) begin
      fails++;
      stop_test();
    end
  end
  ctrl_model u_ctrl (.ref_clk(ref_clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .trig_in(trig_in));
  output_transient_sequencer u_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trig_in(trig_in), .out_set(out_set),
    .seq_busy(seq_busy), .list_done(list_done), .save_ok(save_ok));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] x;
    u_ctrl.xfer(1'b1, a, v, x);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    u_ctrl.xfer(1'b0, a, 32'h0, v);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk(out_set[31:0], 32'h0);
    rd(`OFS_LCOUNT, d);
    chk(d, 32'h1);
    rd(`OFS_CONFIG, d);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, d);
      chk(d, rows[i].ex);
      if (i < 6) chk({16'h0, out_set[16*i +: 16]}, rows[i].wd);
    end
    // single change on ac voltage
    wr(`OFS_CONFIG, 32'h0101);
    wr(`OFS_CTRL, 32'h1);
    @(posedge ref_clk);
    chk(seq_busy, 1'b1);
    wr(`OFS_CTRL, 32'h8);
    repeat (2) @(posedge ref_clk);
    chk(out_set.ac_volt, 16'haa);
    rd(12'h020, d);
    chk(d, 32'haa);
    chk(seq_busy, 1'b0);
    chk(dn, 1);
    // two excursions on dc voltage, width from duty 50 of period 2 us
    wr(12'h044, 32'h55);
    wr(`OFS_PCOUNT, 32'h2);
    wr(`OFS_PPERIOD, 32'h2);
    wr(`OFS_PWIDTH, 32'h0);
    wr(`OFS_CONFIG, 32'h0202);
    wr(`OFS_CTRL, 32'h1);
    u_ctrl.pin_trig();
    hi = 0;
    rise = 0;
    prev = 0;
    repeat (400) begin
      @(posedge ref_clk);
      cur = (out_set.dc_volt === 16'h55);
      hi += cur;
      rise += cur & ~prev;
      prev = cur;
    end
    chk(rise, 2);
    chk(hi >= 78 && hi <= 84, 1);
    chk(out_set.dc_volt, 16'h66);
    // time-paced list, three points, two passes
    wr(12'h060, 32'h3);
    for (int k = 0; k < 3; k++) wr(12'h200 + 12'(4 * k), 32'h11 * (k + 1));
    wr(`OFS_DLEN, 32'h1);
    wr(12'h500, 32'h1);
    wr(`OFS_LCOUNT, 32'h2);
    @(posedge ref_clk);
    chk(save_ok, 1'b0);
    wr(`OFS_CONFIG, 32'h0103);
    wr(`OFS_CTRL, 32'h1);
    last = out_set.ac_volt;
    wr(`OFS_CTRL, 32'h8);
    repeat (400) begin
      @(posedge ref_clk);
      if (out_set.ac_volt !== last) q.push_back(out_set.ac_volt);
      last = out_set.ac_volt;
    end
    chk(q.size(), 6);
    for (int k = 0; k < 6; k++) chk(q[k], 32'h11 * (k % 3 + 1));
    chk(out_set.ac_volt, 16'h33);
    chk(save_ok, 1'b1);
    chk(dn, 3);
    // trigger-paced list with 2 us minimum dwell, then abort
    wr(`OFS_LCOUNT, 32'h1);
    wr(12'h500, 32'h2);
    wr(`OFS_CONFIG, 32'h0107);
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_CTRL, 32'h8);
    repeat (3) @(posedge ref_clk);
    chk(out_set.ac_volt, 16'h11);
    wr(`OFS_CTRL, 32'h8);
    repeat (3) @(posedge ref_clk);
    chk(out_set.ac_volt, 16'h11);
    repeat (100) @(posedge ref_clk);
    wr(`OFS_CTRL, 32'h8);
    repeat (3) @(posedge ref_clk);
    chk(out_set.ac_volt, 16'h22);
    wr(`OFS_CTRL, 32'h2);
    rd(`OFS_STATUS, d);
    chk(d[2:0], 3'h0);
    chk(seq_busy, 1'b0);
    // unequal lengths refused, then a single entry list expands
    wr(12'h064, 32'h2);
    wr(`OFS_CONFIG, 32'h0303);
    wr(`OFS_CTRL, 32'h1);
    rd(`OFS_STATUS, d);
    chk({d[3], d[2:0]}, 4'h8);
    wr(12'h064, 32'h1);
    wr(12'h060, 32'h21);
    wr(`OFS_CTRL, 32'h1);
    rd(`OFS_STATUS, d);
    chk(d[3], 1'b1);
    wr(12'h060, 32'h3);
    wr(12'h584, 32'h2);
    wr(12'h280, 32'h77);
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_CTRL, 32'h8);
    repeat (200) @(posedge ref_clk);
    chk(out_set.ac_volt, 16'h22);
    repeat (200) @(posedge ref_clk);
    chk(out_set.dc_volt, 16'h77);
    chk(out_set.ac_volt, 16'h33);
    wr(`OFS_CTRL, 32'h4);
    rd(`OFS_CONFIG, d);
    chk(d[1:0], 2'h0);
    chk(out_set.ac_volt, 16'haa);
    wr(`OFS_LCOUNT, 32'h5);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk(out_set.ac_volt, 16'h0);
    rd(`OFS_LCOUNT, d);
    chk(d, 32'h1);
    chk(hresp, 1'b0);
    chk(u_ctrl.to_n, 0);
    stop_test();
  end
endmodule
